/* hdl/fault_regs_pkg.sv */
// Purpose: shared constants and carriers of the fault status registers
// Assumes: 16-bit command words, 8-bit command codes
// Notes:   all offsets are command codes, not byte addresses
package fault_regs_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned CODE_W   = 8;
  localparam int unsigned TYPE_W   = 4;
  localparam int unsigned CS_W     = 4;
  localparam int unsigned FLAG_W   = 7;
  localparam int unsigned RECORD_W = FLAG_W + 1;

  // ==========================================================================
  // command codes
  localparam logic [CODE_W-1:0] CODE_CLEAR_FAULTS    = 8'h03;
  localparam logic [CODE_W-1:0] CODE_PRESENT_PHASE56 = 8'hFA;
  localparam logic [CODE_W-1:0] CODE_PRESENT_SPARE   = 8'hFB;
  localparam logic [CODE_W-1:0] CODE_LAST_CAUSE      = 8'hFB;
  localparam logic [CODE_W-1:0] CODE_CLEAR_NVM       = 8'hFF;

  // ==========================================================================
  // field positions
  localparam int unsigned PH5_LSB      = 12;
  localparam int unsigned PH6_LSB      = 8;
  localparam int unsigned STAGE_OT_BIT = 12;
  localparam int unsigned CS_LSB       = 8;
  localparam int unsigned FLAG_LSB     = 0;
  localparam int unsigned VIN_OV_BIT   = 6;
  localparam int unsigned VIN_UV_BIT   = 5;
  localparam int unsigned VTEMP_BIT    = 4;
  localparam int unsigned TSNS_BIT     = 3;
  localparam int unsigned OUT_OV_BIT   = 2;
  localparam int unsigned OUT_UV_BIT   = 1;
  localparam int unsigned OUT_OC_BIT   = 0;

  // ==========================================================================
  // encodings and reset values
  localparam logic [TYPE_W-1:0] TYPE_NONE         = 4'h0;
  localparam logic [TYPE_W-1:0] TYPE_IN_SW_SHORT  = 4'h1;
  localparam logic [TYPE_W-1:0] TYPE_CUR_LIMIT    = 4'h2;
  localparam logic [TYPE_W-1:0] TYPE_OVER_TEMP    = 4'h4;
  localparam logic [TYPE_W-1:0] TYPE_SW_GND_SHORT = 4'h8;
  localparam logic [CS_W-1:0]   CS_NONE           = 4'h0;
  localparam logic [CS_W-1:0]   CS_PHASE_MAX      = 4'h6;
  localparam logic [DATA_W-1:0] RECORD_CLEAR_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_ZERO         = 16'h0000;
  localparam logic [RECORD_W-1:0] RECORD_RESET    = 8'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic              write;
    logic              has_data;
    logic [CODE_W-1:0] code;
    logic [DATA_W-1:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic [TYPE_W-1:0] ph5;
    logic [TYPE_W-1:0] ph6;
  } phase_fault_t;

  // flags: [6] vin ov, [5] vin uv, [4] vtemp ot, [3] tsns ot,
  // [2] out ov, [1] out uv, [0] out oc
  typedef struct packed {
    logic              stage_ot;
    logic [CS_W-1:0]   cs_src;
    logic [FLAG_W-1:0] flags;
  } protect_cause_t;

endpackage

/* hdl/fault_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous levels
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module fault_sync
#(
  parameter int unsigned W = 1
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] agree;
  logic [W-1:0] out_nxt;

  assign agree    = ~(s2_r ^ s3_r);
  assign out_nxt  = (agree & s2_r) | (~agree & out_r);
  assign sync_out = out_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end
    else
    begin
      s1_r  <= async_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

endmodule // fault_sync

/* hdl/sticky_bits.sv */
// Purpose: bank of sticky flags with a common clear
// Assumes: set and clear on the same clock
// Notes:   a set in the clear cycle wins so no event is lost
`timescale 1ns/1ps
module sticky_bits
#(
  parameter int unsigned W = 1
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  // state
  output logic      [W-1:0] q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  assign q_nxt = set | (q_r & ~{W{clr}});
  assign q     = q_r;

  always_ff @(posedge clk)
  begin
    if (rst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

endmodule // sticky_bits

/* hdl/fault_status_registers.sv */
// Purpose: present-fault and last-protection registers behind the
//          command port of the management bus engine
// Assumes: the bus engine delivers one decoded command per cmd_valid,
//          phase and cause fault sources arrive as asynchronous levels
// Notes:   answers come one clock after the command is taken
`timescale 1ns/1ps

// How it works
// - present-fault bits latch when set and stay set until cleared.
// - the clear-faults command resets all latched present-fault bits.
// - phase five fault type sits in bits 15:12 as one-hot codes.
// - phase six fault type sits in bits 11:8 with the same codes.
// - reserved bits of the phase five/six word ignore writes, read zero.
// - the spare present-fault word is all reserved but shares FBh with the record, so a read returns the record.
// - data-less command FFh clears the nonvolatile-memory fault.
// - last-protection record holds causes; writing 0000h clears it.
// - record bit 12 flags a power-stage temperature trigger.
// - record bits 11:8 name the phase whose current sense tripped.
// - record bits 6, 5, 4: input ov, input uvlo, regulator temp ot.
// - record bits 3..0: sense ot, output ov, output uv, output oc.
module fault_status_registers
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // command port from the bus engine
  input  wire logic                          cmd_valid,
  input  wire fault_regs_pkg::cmd_req_t      cmd_req,
  // answers to the bus engine
  output logic                               rd_valid,
  output logic [fault_regs_pkg::DATA_W-1:0]  rd_data,
  output logic                               cmd_done,
  output logic                               cmd_reject,
  // fault sources, asynchronous levels
  input  wire fault_regs_pkg::phase_fault_t  phase_fault_raw,
  input  wire fault_regs_pkg::protect_cause_t cause_raw,
  // nonvolatile-memory fault, same-clock event and state
  input  wire logic                          nvm_fault_evt,
  output logic                               nvm_fault,
  // summary of latched present faults
  output logic                               present_fault_any
);

  // ==========================================================================
  // synchronised fault sources
  // four clocks of lag buy immunity to one-cycle glitches on the pins
  localparam int unsigned PH_W = 2 * fault_regs_pkg::TYPE_W;
  localparam int unsigned CA_W = fault_regs_pkg::RECORD_W
                                 + fault_regs_pkg::CS_W;

  fault_regs_pkg::phase_fault_t   phase_sync;
  fault_regs_pkg::protect_cause_t cause_sync;

  fault_sync #(.W(PH_W)) u_sync_phase
  (
    .clk      (clk),
    .rst      (rst),
    .async_in (phase_fault_raw),
    .sync_out (phase_sync)
  );

  fault_sync #(.W(CA_W)) u_sync_cause
  (
    .clk      (clk),
    .rst      (rst),
    .async_in (cause_raw),
    .sync_out (cause_sync)
  );

  // ==========================================================================
  // command decode
  logic is_wr;
  logic is_rd;
  logic hit_phase56;
  logic hit_spare;
  logic hit_last;
  logic hit_clr_faults;
  logic hit_clr_nvm;
  logic hit_reg;
  logic data_zero;

  assign is_wr = cmd_valid & cmd_req.write;
  assign is_rd = cmd_valid & ~cmd_req.write;

  assign hit_phase56    = cmd_req.code == fault_regs_pkg::CODE_PRESENT_PHASE56;
  assign hit_last       = cmd_req.code == fault_regs_pkg::CODE_LAST_CAUSE;
  // the spare word only answers where the record does not share its code
  assign hit_spare      = (cmd_req.code == fault_regs_pkg::CODE_PRESENT_SPARE)
                          & ~hit_last;
  assign hit_clr_faults = cmd_req.code == fault_regs_pkg::CODE_CLEAR_FAULTS;
  assign hit_clr_nvm    = cmd_req.code == fault_regs_pkg::CODE_CLEAR_NVM;
  // words that answer a read
  assign hit_reg        = hit_phase56 | hit_spare | hit_last;
  assign data_zero      = cmd_req.data == fault_regs_pkg::RECORD_CLEAR_WORD;

  // send-byte style commands carry no data word
  logic clear_faults;
  logic clear_nvm;
  logic record_clear;

  assign clear_faults = is_wr & hit_clr_faults & ~cmd_req.has_data;
  assign clear_nvm    = is_wr & hit_clr_nvm & ~cmd_req.has_data;
  assign record_clear = is_wr & hit_last & cmd_req.has_data
                        & data_zero;

  // writes to read-only or reserved words change nothing
  logic wr_ok;
  logic rd_ok;
  logic reject_nxt;

  assign wr_ok = clear_faults | clear_nvm | record_clear;
  assign rd_ok = is_rd & hit_reg;

  // ==========================================================================
  // refusals
  // a refused command changes no state; the reject pulse is its only trace
  logic refuse_wr;
  logic refuse_rd;

  assign refuse_wr  = is_wr & ~wr_ok;
  assign refuse_rd  = is_rd & ~rd_ok;
  assign reject_nxt = refuse_wr | refuse_rd;

  // ==========================================================================
  // present faults of phases five and six
  // one synchronised cycle of a fault type is enough to latch it
  fault_regs_pkg::phase_fault_t present_q;

  sticky_bits #(.W(PH_W)) u_present
  (
    .clk (clk),
    .rst (rst),
    .set (phase_sync),
    .clr (clear_faults),
    .q   (present_q)
  );

  // ==========================================================================
  // last-protection record
  logic [fault_regs_pkg::RECORD_W-1:0] record_set;
  logic [fault_regs_pkg::RECORD_W-1:0] record_q;

  // the clear is a plain strobe, so a cause in the clear cycle survives
  assign record_set = {cause_sync.stage_ot, cause_sync.flags};

  sticky_bits #(.W(fault_regs_pkg::RECORD_W)) u_record
  (
    .clk (clk),
    .rst (rst),
    .set (record_set),
    .clr (record_clear),
    .q   (record_q)
  );

  // phase code keeps the latest valid phase; codes above six are ignored
  logic [fault_regs_pkg::CS_W-1:0] cs_src_r;
  logic [fault_regs_pkg::CS_W-1:0] cs_src_nxt;
  logic                            cs_valid;

  assign cs_valid = (cause_sync.cs_src != fault_regs_pkg::CS_NONE)
                    & (cause_sync.cs_src <= fault_regs_pkg::CS_PHASE_MAX);
  assign cs_src_nxt = cs_valid     ? cause_sync.cs_src :
                      record_clear ? fault_regs_pkg::CS_NONE :
                                     cs_src_r;

  always_ff @(posedge clk)
  begin
    if (rst)
      cs_src_r <= fault_regs_pkg::CS_NONE;
    else
      cs_src_r <= cs_src_nxt;
  end

  // ==========================================================================
  // nonvolatile-memory fault
  logic nvm_fault_r;
  logic nvm_fault_nxt;

  // a new fault in the clear cycle survives the clear
  assign nvm_fault_nxt = nvm_fault_evt | (nvm_fault_r & ~clear_nvm);

  always_ff @(posedge clk)
  begin
    if (rst)
      nvm_fault_r <= 1'b0;
    else
      nvm_fault_r <= nvm_fault_nxt;
  end

  // ==========================================================================
  // read words
  logic [fault_regs_pkg::DATA_W-1:0] word_phase56;
  logic [fault_regs_pkg::DATA_W-1:0] word_spare;
  logic [fault_regs_pkg::DATA_W-1:0] word_last;
  logic [fault_regs_pkg::DATA_W-1:0] rd_mux;

  always_comb
  begin
    word_phase56 = fault_regs_pkg::WORD_ZERO;
    word_phase56[fault_regs_pkg::PH5_LSB +: fault_regs_pkg::TYPE_W] =
      present_q.ph5;
    word_phase56[fault_regs_pkg::PH6_LSB +: fault_regs_pkg::TYPE_W] =
      present_q.ph6;
  end

  assign word_spare = fault_regs_pkg::WORD_ZERO;

  always_comb
  begin
    word_last = fault_regs_pkg::WORD_ZERO;
    word_last[fault_regs_pkg::STAGE_OT_BIT] =
      record_q[fault_regs_pkg::FLAG_W];
    word_last[fault_regs_pkg::CS_LSB +: fault_regs_pkg::CS_W] =
      cs_src_r;
    word_last[fault_regs_pkg::VIN_OV_BIT] =
      record_q[fault_regs_pkg::VIN_OV_BIT];
    word_last[fault_regs_pkg::VIN_UV_BIT] =
      record_q[fault_regs_pkg::VIN_UV_BIT];
    word_last[fault_regs_pkg::VTEMP_BIT] =
      record_q[fault_regs_pkg::VTEMP_BIT];
    word_last[fault_regs_pkg::TSNS_BIT] =
      record_q[fault_regs_pkg::TSNS_BIT];
    word_last[fault_regs_pkg::OUT_OV_BIT] =
      record_q[fault_regs_pkg::OUT_OV_BIT];
    word_last[fault_regs_pkg::OUT_UV_BIT] =
      record_q[fault_regs_pkg::OUT_UV_BIT];
    word_last[fault_regs_pkg::OUT_OC_BIT] =
      record_q[fault_regs_pkg::OUT_OC_BIT];
  end

  // record and spare share a code; the record is the one answered
  assign rd_mux = hit_phase56 ? word_phase56 :
                  hit_last    ? word_last :
                  hit_spare   ? word_spare :
                                fault_regs_pkg::WORD_ZERO;

  // ==========================================================================
  // answer registers
  // every taken command gets exactly one of the three pulses
  logic                              rd_valid_r;
  logic [fault_regs_pkg::DATA_W-1:0] rd_data_r;
  logic [fault_regs_pkg::DATA_W-1:0] rd_data_nxt;
  logic                              cmd_done_r;
  logic                              cmd_reject_r;

  // data holds between reads so the engine may shift it out slowly
  assign rd_data_nxt = rd_ok ? rd_mux : rd_data_r;

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_valid_r <= 1'b0;
    else
      rd_valid_r <= rd_ok;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data_r <= fault_regs_pkg::WORD_ZERO;
    else
      rd_data_r <= rd_data_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cmd_done_r <= 1'b0;
    else
      cmd_done_r <= wr_ok;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cmd_reject_r <= 1'b0;
    else
      cmd_reject_r <= reject_nxt;
  end

  // ==========================================================================
  // fault summary
  // one clock behind the latches, registered like every other output
  logic present_any_r;
  logic present_any_nxt;

  assign present_any_nxt = |present_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      present_any_r <= 1'b0;
    else
      present_any_r <= present_any_nxt;
  end

  // ==========================================================================
  // outputs, all straight from flip-flops
  assign rd_valid          = rd_valid_r;
  assign rd_data           = rd_data_r;
  assign cmd_done          = cmd_done_r;
  assign cmd_reject        = cmd_reject_r;
  assign nvm_fault         = nvm_fault_r;
  assign present_fault_any = present_any_r;

endmodule // fault_status_registers

/* dv/fault_status_registers_sva.sv */
// Purpose: port-level checks of the fault status registers
// Assumes: one answer pulse one clock after each command
// Notes:   bound into every instance of the top module
`timescale 1ns/1ps
module fault_status_registers_sva
(
  // clock and reset
  input wire logic                                clk,
  input wire logic                                rst,
  // command port
  input wire logic                                cmd_valid,
  input wire fault_regs_pkg::cmd_req_t            cmd_req,
  // answers
  input wire logic                                rd_valid,
  input wire logic [fault_regs_pkg::DATA_W-1:0]   rd_data,
  input wire logic                                cmd_done,
  input wire logic                                cmd_reject,
  // faults
  input wire fault_regs_pkg::phase_fault_t        phase_fault_raw,
  input wire fault_regs_pkg::protect_cause_t      cause_raw,
  input wire logic                                nvm_fault_evt,
  input wire logic                                nvm_fault,
  input wire logic                                present_fault_any
);
  // ==========
  // decode
  wire wr_nd   = cmd_valid & cmd_req.write & ~cmd_req.has_data;
  wire clr_cmd = wr_nd & (cmd_req.code == 8'h03);
  wire nvm_cmd = wr_nd & (cmd_req.code == 8'hFF);
  wire wr_fa   = cmd_valid & cmd_req.write & (cmd_req.code == 8'hFA);
  wire wr_fb   = cmd_valid & cmd_req.write & (cmd_req.code == 8'hFB);

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========
  // checks
  AST_ONE_ANSWER:
    assert property (cmd_valid |=> $onehot({rd_valid, cmd_done, cmd_reject}))
    else $error("answer count wrong");
  AST_PRESENT_STICKY:
    assert property (present_fault_any && !$past(clr_cmd) |=> present_fault_any)
    else $error("present fault lost");
  AST_RSVD_LOW:
    assert property (rd_valid && $past(cmd_req.code) == 8'hFA
                     |-> rd_data[7:0] == 8'h00)
    else $error("reserved bits set");
  AST_REC_RSVD:
    assert property (rd_valid && $past(cmd_req.code) == 8'hFB
                     |-> rd_data[15:13] == 3'h0 && !rd_data[7])
    else $error("record reserved bits set");
  AST_CS_RANGE:
    assert property (rd_valid && $past(cmd_req.code) == 8'hFB
                     |-> rd_data[11:8] <= 4'h6)
    else $error("phase code out of range");
  AST_NVM_SET:
    assert property (nvm_fault_evt |=> nvm_fault)
    else $error("nvm fault not set");
  AST_NVM_CLEAR:
    assert property (nvm_cmd && !nvm_fault_evt |=> !nvm_fault && cmd_done)
    else $error("nvm fault not cleared");
  AST_FA_WR_REJ:
    assert property (wr_fa |=> cmd_reject && $stable(rd_data))
    else $error("write to read-only word taken");
  AST_REC_WR_REJ:
    assert property (wr_fb && cmd_req.data != 16'h0000 |=> cmd_reject)
    else $error("nonzero record write taken");
  // a source gone three and four clocks back can no longer refill the latch
  AST_CLEAR_DONE:
    assert property (clr_cmd && $past(phase_fault_raw, 3) == 8'h00
                     && $past(phase_fault_raw, 4) == 8'h00
                     |-> ##1 cmd_done ##1 !present_fault_any)
    else $error("clear faults not done");
endmodule // fault_status_registers_sva

bind fault_status_registers fault_status_registers_sva sva_u
(
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
  .rd_valid(rd_valid), .rd_data(rd_data), .cmd_done(cmd_done),
  .cmd_reject(cmd_reject), .phase_fault_raw(phase_fault_raw),
  .cause_raw(cause_raw), .nvm_fault_evt(nvm_fault_evt),
  .nvm_fault(nvm_fault), .present_fault_any(present_fault_any)
);

/* dv/fault_host_model.sv */
// Purpose: management bus host issuing one command at a time
// Assumes: answer pulse one clock after the command is taken
// Notes:   record clear wait counts clocks of a 100 ns period
`timescale 1ns/1ps
module fault_host_model
#(
  parameter int unsigned CLR_WAIT = 50000
)
(
  // clock
  input  wire logic                               clk,
  // command port
  output logic                                    cmd_valid,
  output fault_regs_pkg::cmd_req_t                cmd_req,
  // answers
  input  wire logic                               rd_valid,
  input  wire logic [fault_regs_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                               cmd_done,
  input  wire logic                               cmd_reject
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_req   = '0;
  end

  // kind: 1 read, 2 done, 3 refused, 0 no answer
  task automatic send(input logic w, input logic hd, input logic [7:0] c,
                      input logic [15:0] d, output logic [1:0] kind,
                      output logic [15:0] q);
    kind = 2'h0;
    q    = 16'h0000;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_req   <= '{write: w, has_data: hd, code: c, data: d};
    @(posedge clk);
    cmd_valid <= 1'b0;
    // released lines must not look like the last request
    cmd_req   <= '{write: ~w, has_data: ~hd, code: ~c, data: ~d};
    for (int k = 0; k < 4 && kind == 2'h0; k++)
    begin
      #1;
      if (rd_valid)
      begin
        kind = 2'h1;
        q    = rd_data;
      end
      else if (cmd_done)
        kind = 2'h2;
      else if (cmd_reject)
        kind = 2'h3;
      if (kind == 2'h0)
        @(posedge clk);
    end
  endtask

  task automatic clear_record(output logic [1:0] kind,
                              output logic [15:0] q);
    send(1'b1, 1'b1, 8'hFB, 16'h0000, kind, q);
    repeat (CLR_WAIT) @(posedge clk);
  endtask
endmodule // fault_host_model

/* dv/tb_fault_status_registers.sv */
// Purpose: self-checking bench of the fault status registers
// Assumes: fault levels need four edges to be seen
// Notes:   the record is cleared once, so the full wait costs little
`timescale 1ns/1ps
module tb_fault_status_registers;
  logic                           clk;
  logic                           rst;
  logic                           cmd_valid;
  fault_regs_pkg::cmd_req_t       cmd_req;
  logic                           rd_valid;
  logic [15:0]                    rd_data;
  logic                           cmd_done;
  logic                           cmd_reject;
  fault_regs_pkg::phase_fault_t   phase_fault_raw;
  fault_regs_pkg::protect_cause_t cause_raw;
  logic                           nvm_fault_evt;
  logic                           nvm_fault;
  logic                           present_fault_any;
  int                             errors;
  int                             checked;

  always #50 clk = ~clk;

  fault_status_registers dut_u
  (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
    .rd_valid(rd_valid), .rd_data(rd_data), .cmd_done(cmd_done),
    .cmd_reject(cmd_reject), .phase_fault_raw(phase_fault_raw),
    .cause_raw(cause_raw), .nvm_fault_evt(nvm_fault_evt),
    .nvm_fault(nvm_fault), .present_fault_any(present_fault_any)
  );

  fault_host_model #(.CLR_WAIT(50000)) host_u
  (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
    .rd_valid(rd_valid), .rd_data(rd_data), .cmd_done(cmd_done),
    .cmd_reject(cmd_reject)
  );

  // ==========
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic hd, input logic [7:0] c,
                      input logic [15:0] d, input logic [1:0] ek,
                      input logic [15:0] eq);
    logic [1:0]  k;
    logic [15:0] q;
    host_u.send(w, hd, c, d, k, q);
    check({14'h0000, k}, {14'h0000, ek});
    check(q, eq);
  endtask

  // wait out the input synchroniser
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_reset;
    xfer(1'b0, 1'b0, 8'hFA, 16'h0000, 2'h1, 16'h0000);
    xfer(1'b0, 1'b0, 8'hFB, 16'h0000, 2'h1, 16'h0000);
    check({15'h0000, nvm_fault}, 16'h0000);
  endtask

  task automatic t_phase;
    logic [3:0] c5;
    logic [3:0] c6;
    for (int i = 0; i < 4; i++)
    begin
      c5 = 4'h1 << i;
      c6 = 4'h8 >> i;
      @(posedge clk);
      phase_fault_raw <= '{ph5: c5, ph6: c6};
      settle();
      phase_fault_raw <= '0;
      settle();
      xfer(1'b0, 1'b0, 8'hFA, 16'h0000, 2'h1, {c5, c6, 8'h00});
      xfer(1'b1, 1'b1, 8'hFA, 16'hFFFF, 2'h3, 16'h0000);
      xfer(1'b0, 1'b0, 8'hFA, 16'h0000, 2'h1, {c5, c6, 8'h00});
      check({15'h0000, present_fault_any}, 16'h0001);
      xfer(1'b1, 1'b0, 8'h03, 16'h0000, 2'h2, 16'h0000);
      xfer(1'b0, 1'b0, 8'hFA, 16'h0000, 2'h1, 16'h0000);
    end
  endtask

  task automatic t_record;
    fault_regs_pkg::protect_cause_t c;
    fault_regs_pkg::protect_cause_t acc;
    logic [1:0]                     k;
    logic [15:0]                    q;
    acc = '0;
    for (int i = 0; i < 7; i++)
    begin
      c = '{stage_ot: i[0], cs_src: 4'(i % 6 + 1), flags: 7'h01 << i};
      // causes pile up until cleared; the phase code is the latest one
      acc = '{stage_ot: acc.stage_ot | c.stage_ot, cs_src: c.cs_src,
              flags: acc.flags | c.flags};
      @(posedge clk);
      cause_raw <= c;
      settle();
      cause_raw <= '0;
      settle();
      xfer(1'b0, 1'b0, 8'hFB, 16'h0000, 2'h1,
           {3'h0, acc.stage_ot, acc.cs_src, 1'b0, acc.flags});
      xfer(1'b1, 1'b1, 8'hFB, 16'h0100, 2'h3, 16'h0000);
    end
    host_u.clear_record(k, q);
    check({14'h0000, k}, 16'h0002);
    xfer(1'b0, 1'b0, 8'hFB, 16'h0000, 2'h1, 16'h0000);
  endtask

  task automatic t_nvm;
    @(posedge clk);
    nvm_fault_evt <= 1'b1;
    @(posedge clk);
    nvm_fault_evt <= 1'b0;
    @(posedge clk);
    #1;
    check({15'h0000, nvm_fault}, 16'h0001);
    xfer(1'b1, 1'b1, 8'hFF, 16'h0000, 2'h3, 16'h0000);
    check({15'h0000, nvm_fault}, 16'h0001);
    xfer(1'b1, 1'b0, 8'hFF, 16'h0000, 2'h2, 16'h0000);
    check({15'h0000, nvm_fault}, 16'h0000);
    xfer(1'b0, 1'b0, 8'hFF, 16'h0000, 2'h3, 16'h0000);
    xfer(1'b0, 1'b0, 8'h55, 16'h0000, 2'h3, 16'h0000);
  endtask

  initial
  begin
    clk             = 1'b0;
    rst             = 1'b1;
    errors          = 0;
    checked         = 0;
    phase_fault_raw = '0;
    cause_raw       = '0;
    nvm_fault_evt   = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_phase();
    t_record();
    t_nvm();
    end_sim();
  end
endmodule // tb_fault_status_registers
